// file: include/gear_feed_pkg.sv
// shared constants and carrier types for the gearing and feedrate block
package gear_feed_pkg;
  // clock and timebase figures
  localparam int CLK_NS = 10;               // mclk period
  localparam int TIMEBASE_NS = 10000;       // servo sample and raw timebase step
  localparam int TIMEBASE_CYC = TIMEBASE_NS / CLK_NS;
  localparam int MS_NS = 1000000;           // one millisecond of dwell or delay
  localparam int TICKS_PER_MS = MS_NS / TIMEBASE_NS;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RATIO_OFS = 8'h04;
  localparam logic [7:0] SLEW_OFS = 8'h08;
  localparam logic [7:0] FEED_OFS = 8'h0c;
  localparam logic [7:0] FEED_DEF_OFS = 8'h10;
  localparam logic [7:0] DWELL_OFS = 8'h14;
  localparam logic [7:0] DELAY_OFS = 8'h18;
  localparam logic [7:0] SEG_DIST_OFS = 8'h1c;
  localparam logic [7:0] SEG_VEL_OFS = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;
  localparam logic [7:0] EXT_POS_OFS = 8'h28;
  localparam logic [7:0] TOTAL_OFS = 8'h2c;
  // control field positions
  localparam int CTRL_FOLLOW = 0;
  localparam int CTRL_ACCEL_CAP = 1;
  localparam int CTRL_STEP_DIR = 2;
  localparam int CTRL_ONE_WAY_DIR = 3;
  localparam int CTRL_STAGE_SEL = 4;
  localparam int CTRL_LIMIT_TYPE = 5;       // two bits, 6:5
  localparam int CTRL_FEED_ANALOG = 7;
  localparam int CTRL_WIDTH = 8;
  // status field positions
  localparam int ST_LIMITING = 0;
  localparam int ST_LAG = 1;
  localparam int ST_PAUSE = 2;
  localparam int ST_SEG_ACTIVE = 3;
  localparam int ST_SEG_BRANCH = 4;
  localparam int ST_SEG_DONE = 5;
  localparam int ST_FOLLOWING = 6;
  // reset values and numeric limits
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [31:0] RATIO_RST = 32'h0001_0000;  // 1.0 in 16.16
  localparam logic [31:0] SLEW_RST = 32'h0000_0001;
  localparam logic [7:0] FEED_RST = 8'h64;            // 100 percent
  localparam logic [7:0] FEED_MAX = 8'hc8;            // 200 percent
  localparam logic [8:0] FEED_UNITY = 9'h064;
  localparam int FRAC_BITS = 16;
  // one-way limiter types
  typedef enum logic [1:0] {
    LIM_OFF = 2'b00,
    LIM_CLIP = 2'b01,
    LIM_RECOVER = 2'b10
  } limit_type_t;
  // the three command sources summed beside the gear
  typedef struct packed {
    logic [31:0] profile;
    logic [31:0] jog;
    logic [31:0] cam;
  } cmd_sources_t;
  // limiter result
  typedef struct packed {
    logic [31:0] value;
    logic [31:0] owed;
    logic limiting;
  } limit_res_t;
  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// file: src/electronic_gear_feedrate.sv
// external gear command, command summing and feedrate timebase of a positioning drive
//
// Contract
// - motor counts follow secondary counts by ratio
// - negative ratio reverses follower direction
// - following only while follow enable set
// - acceleration capped at slew value when enabled
// - enabling on moving master ramps up smoothly
// - cap stays on; follower lags when exceeded
// - quadrature or step-direction, never both
// - following survives program end, stops on disable
// - step-direction mode scales steps by ratio
// - one-way limiter with direction, type, flag
// - select limiter before or after gear/slew
// - total command sums four components
// - incremental moves superimpose on gear command
// - feedrate 0..200 percent, 100 means unchanged
// - feedrate scales motion timebase and dwells
// - feedrate optionally taken from analog input
// - program feedrate reverts to default at end
// - dwell scaled by feedrate, delay never
// - conditional segment stops when condition true
// - external command only from secondary channel
//
// The register addresses and the plain strobed port were chosen for this implementation.
module electronic_gear_feedrate (
  input wire logic mclk,
  input wire logic reset,
  input wire gear_feed_pkg::reg_req_t req,
  output logic [31:0] rdata,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic cond_in,
  input wire logic drive_enable,
  input wire logic program_running,
  input wire logic [7:0] analog_feed,
  input wire gear_feed_pkg::cmd_sources_t sources,
  output logic [31:0] total_cmd,
  output logic [31:0] external_command_component,
  output logic motion_tick,
  output logic one_way_limiting_flag,
  output logic pause_busy
);

  // clamp a percentage to the legal feedrate span
  function automatic logic [7:0] clamp_feed(input logic [7:0] pct);
    clamp_feed = (pct > gear_feed_pkg::FEED_MAX) ? gear_feed_pkg::FEED_MAX : pct;
  endfunction

  // one-way limiter, shared by the pre-gear and post-slew positions
  function automatic gear_feed_pkg::limit_res_t one_way(input logic [31:0] val,
      input logic [31:0] owed, input logic [1:0] kind, input logic rev);
    logic signed [31:0] x;
    logic signed [31:0] used;
    gear_feed_pkg::limit_res_t r;
    x = rev ? -$signed(val) : $signed(val);
    used = 32'sh0;
    r.value = val;
    r.owed = owed;
    r.limiting = 1'b0;
    if (kind != gear_feed_pkg::LIM_OFF) begin
      if (x < 0) begin
        // reverse motion is blocked; the recover type remembers it
        r.owed = (kind == gear_feed_pkg::LIM_RECOVER) ? owed - x : owed;
        x = 32'sh0;
        r.limiting = 1'b1;
      end else if (owed != 32'h0) begin
        // forward motion first pays back what was blocked
        used = (x < $signed(owed)) ? x : $signed(owed);
        x = x - used;
        r.owed = owed - used;
        r.limiting = 1'b1;
      end
      r.value = rev ? -x : x;
    end
    one_way = r;
  endfunction

  // ---------------- registers ----------------
  logic [7:0] ctrl_reg;        // control bits
  logic [31:0] ratio_reg;      // signed 16.16 gear ratio
  logic [31:0] slew_reg;       // max velocity change per sample
  logic [7:0] feed_reg;        // working feedrate percent
  logic [7:0] feed_def_reg;    // stored default feedrate
  logic [31:0] seg_vel_reg;    // conditional segment speed per motion tick
  logic [31:0] rdata_reg;      // read data, valid the cycle after the strobe

  // named control fields
  wire follow_enable = ctrl_reg[gear_feed_pkg::CTRL_FOLLOW];
  wire accel_cap_enable = ctrl_reg[gear_feed_pkg::CTRL_ACCEL_CAP];
  wire step_dir_mode = ctrl_reg[gear_feed_pkg::CTRL_STEP_DIR];
  wire one_way_direction = ctrl_reg[gear_feed_pkg::CTRL_ONE_WAY_DIR];
  wire one_way_stage_select = ctrl_reg[gear_feed_pkg::CTRL_STAGE_SEL];
  wire [1:0] one_way_limit_type = ctrl_reg[gear_feed_pkg::CTRL_LIMIT_TYPE +: 2];
  wire feed_from_analog = ctrl_reg[gear_feed_pkg::CTRL_FEED_ANALOG];

  // write decode
  wire wr_ctrl = req.wr && (req.addr == gear_feed_pkg::CTRL_OFS);
  wire wr_ratio = req.wr && (req.addr == gear_feed_pkg::RATIO_OFS);
  wire wr_slew = req.wr && (req.addr == gear_feed_pkg::SLEW_OFS);
  wire wr_feed = req.wr && (req.addr == gear_feed_pkg::FEED_OFS);
  wire wr_feed_def = req.wr && (req.addr == gear_feed_pkg::FEED_DEF_OFS);
  wire wr_dwell = req.wr && (req.addr == gear_feed_pkg::DWELL_OFS);
  wire wr_delay = req.wr && (req.addr == gear_feed_pkg::DELAY_OFS);
  wire wr_seg_dist = req.wr && (req.addr == gear_feed_pkg::SEG_DIST_OFS);
  wire wr_seg_vel = req.wr && (req.addr == gear_feed_pkg::SEG_VEL_OFS);

  // ---------------- pin synchronisers ----------------
  // pins: 0 enc_a/step, 1 enc_b/dir, 2 condition, 3 drive enable
  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic [3:0] pin_reg;         // filtered level, moves when stages 2 and 3 agree
  logic [3:0] pin_prev_reg;    // filtered level one cycle back
  wire [3:0] pin_agree = ~(sync2_reg ^ sync3_reg);
  wire [3:0] pin_next = (pin_agree & sync3_reg) | (~pin_agree & pin_reg);

  // three-stage capture; the first stage feeds only the second
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      sync3_reg <= 4'h0;
      pin_reg <= 4'h0;
      pin_prev_reg <= 4'h0;
    end else begin
      sync1_reg <= {drive_enable, cond_in, enc_b, enc_a};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= pin_next;
      pin_prev_reg <= pin_reg;
    end
  end

  // ---------------- master count decode ----------------
  // one channel only; the mode bit picks the decoder, so both cannot act
  wire a_chg = pin_reg[0] ^ pin_prev_reg[0];
  wire b_chg = pin_reg[1] ^ pin_prev_reg[1];
  wire quad_step = a_chg ^ b_chg;                      // both moving at once is ignored
  wire quad_up = pin_prev_reg[0] ^ pin_reg[1];
  wire sd_step = pin_reg[0] & ~pin_prev_reg[0];        // rising step edge
  wire sd_up = ~pin_reg[1];                            // direction low counts up
  wire cnt_step = step_dir_mode ? sd_step : quad_step;
  wire cnt_up = step_dir_mode ? sd_up : quad_up;
  wire drive_on = pin_reg[3];
  wire cond_true = pin_reg[2];

  // ---------------- timebase divider ----------------
  logic [9:0] div_reg;         // counts one servo sample
  wire base_tick = (div_reg == 10'(gear_feed_pkg::TIMEBASE_CYC - 1));

  // raw timebase, independent of the feedrate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_reg <= 10'h000;
    end else begin
      div_reg <= base_tick ? 10'h000 : div_reg + 10'h001;
    end
  end

  // master counts gathered over one sample
  logic signed [15:0] mdelta_reg;
  wire signed [15:0] cnt_inc = cnt_step ? (cnt_up ? 16'sh1 : -16'sh1) : 16'sh0;
  wire signed [15:0] sample_delta = mdelta_reg + cnt_inc;

  // collect counts, hand them over on the sample tick
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mdelta_reg <= 16'sh0;
    end else begin
      mdelta_reg <= base_tick ? 16'sh0 : sample_delta;
    end
  end

  // ---------------- gear, slew and one-way stages ----------------
  logic [15:0] rem_reg;        // fractional count carried between samples
  logic signed [31:0] vel_reg; // follower counts per sample after the cap
  logic [31:0] owed_reg;       // blocked reverse motion for the recover type
  logic [31:0] ext_pos_reg;    // external command component
  logic lag_reg;               // cap is clamping, follower is losing lock
  logic limiting_reg;          // one-way limiter is holding motion back

  wire following = follow_enable & drive_on;  // program state plays no part
  wire [31:0] delta_ext = {{16{sample_delta[15]}}, sample_delta};
  wire gear_feed_pkg::limit_res_t pre_lim =
      one_way(delta_ext, owed_reg, one_way_limit_type, one_way_direction);
  wire [31:0] gear_in = one_way_stage_select ? delta_ext : pre_lim.value;
  // signed product keeps the sign of the ratio
  wire signed [63:0] gear_prod = $signed(gear_in) * $signed(ratio_reg)
      + $signed({48'h0, rem_reg});
  wire signed [31:0] vel_tgt = 32'(gear_prod >>> gear_feed_pkg::FRAC_BITS);
  wire signed [31:0] vel_diff = vel_tgt - vel_reg;
  wire signed [31:0] slew_s = $signed(slew_reg);
  wire cap_hi = accel_cap_enable && (vel_diff > slew_s);
  wire cap_lo = accel_cap_enable && (vel_diff < -slew_s);
  // with the cap enabled, velocity steps by at most the slew value per sample
  wire signed [31:0] vel_next = cap_hi ? vel_reg + slew_s :
                                cap_lo ? vel_reg - slew_s : vel_tgt;
  wire gear_feed_pkg::limit_res_t post_lim =
      one_way(vel_next, owed_reg, one_way_limit_type, one_way_direction);
  wire [31:0] pos_inc = one_way_stage_select ? post_lim.value : vel_next;
  wire [31:0] owed_next = one_way_stage_select ? post_lim.owed : pre_lim.owed;
  wire lim_next = one_way_stage_select ? post_lim.limiting : pre_lim.limiting;

  // one gear step per sample; a disabled gear drops its speed and remainder at once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rem_reg <= 16'h0;
      vel_reg <= 32'sh0;
      owed_reg <= 32'h0;
      ext_pos_reg <= 32'h0;
      lag_reg <= 1'b0;
      limiting_reg <= 1'b0;
    end else if (!following) begin
      // disable stops gear motion; position already commanded is kept
      rem_reg <= 16'h0;
      vel_reg <= 32'sh0;
      owed_reg <= 32'h0;
      lag_reg <= 1'b0;
      limiting_reg <= 1'b0;
    end else if (base_tick) begin
      rem_reg <= gear_prod[15:0];
      vel_reg <= vel_next;
      owed_reg <= owed_next;
      ext_pos_reg <= ext_pos_reg + pos_inc;
      lag_reg <= cap_hi | cap_lo;
      limiting_reg <= lim_next;
    end
  end

  // ---------------- feedrate ----------------
  wire [7:0] eff_feed = feed_from_analog ? clamp_feed(analog_feed) : feed_reg;
  logic prog_run_reg;          // program state one cycle back
  wire prog_end = ~program_running & prog_run_reg;
  logic [8:0] facc_reg;        // feedrate accumulator in percent
  logic mtick_reg;             // scaled timebase pulse
  wire facc_full = (facc_reg >= gear_feed_pkg::FEED_UNITY);
  // each raw step adds the percentage, each scaled step spends 100
  wire [8:0] facc_next = facc_reg + (base_tick ? {1'b0, eff_feed} : 9'h000)
                         - (facc_full ? gear_feed_pkg::FEED_UNITY : 9'h000);

  // feedrate registers and the scaled timebase
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      feed_reg <= gear_feed_pkg::FEED_RST;
      feed_def_reg <= gear_feed_pkg::FEED_RST;
      prog_run_reg <= 1'b0;
      facc_reg <= 9'h000;
      mtick_reg <= 1'b0;
    end else begin
      prog_run_reg <= program_running;
      facc_reg <= facc_next;
      mtick_reg <= facc_full;
      if (wr_feed_def) begin
        feed_def_reg <= clamp_feed(req.wdata[7:0]);
      end
      if (prog_end) begin
        feed_reg <= feed_def_reg;
      end else if (wr_feed) begin
        feed_reg <= clamp_feed(req.wdata[7:0]);
      end
    end
  end

  // ---------------- dwell and delay ----------------
  logic [31:0] dwell_reg;      // remaining scaled ticks
  logic [31:0] delay_reg;      // remaining raw ticks
  wire [31:0] ms_ticks = 32'(req.wdata * gear_feed_pkg::TICKS_PER_MS);

  // dwell runs on the scaled timebase, delay on the raw one
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dwell_reg <= 32'h0;
      delay_reg <= 32'h0;
    end else begin
      if (wr_dwell) begin
        dwell_reg <= ms_ticks;
      end else if (mtick_reg && dwell_reg != 32'h0) begin
        dwell_reg <= dwell_reg - 32'h1;
      end
      if (wr_delay) begin
        delay_reg <= ms_ticks;
      end else if (base_tick && delay_reg != 32'h0) begin
        delay_reg <= delay_reg - 32'h1;
      end
    end
  end

  // ---------------- conditional segment ----------------
  logic [31:0] seg_rem_reg;    // distance left
  logic [31:0] seg_pos_reg;    // segment contribution to the profile component
  logic seg_branch_reg;        // condition met, branch to be taken
  logic seg_done_reg;          // full distance moved
  wire seg_active = (seg_rem_reg != 32'h0);
  wire [31:0] seg_step = (seg_vel_reg < seg_rem_reg) ? seg_vel_reg : seg_rem_reg;

  // segment advances on the scaled timebase; a true condition ends it early
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      seg_vel_reg <= 32'h0;
      seg_rem_reg <= 32'h0;
      seg_pos_reg <= 32'h0;
      seg_branch_reg <= 1'b0;
      seg_done_reg <= 1'b0;
    end else begin
      if (wr_seg_vel) begin
        seg_vel_reg <= req.wdata;
      end
      if (wr_seg_dist) begin
        // a new segment clears the old outcome
        seg_rem_reg <= req.wdata;
        seg_branch_reg <= 1'b0;
        seg_done_reg <= 1'b0;
      end else if (seg_active && cond_true) begin
        seg_rem_reg <= 32'h0;
        seg_branch_reg <= 1'b1;
      end else if (seg_active && mtick_reg) begin
        seg_rem_reg <= seg_rem_reg - seg_step;
        seg_pos_reg <= seg_pos_reg + seg_step;
        seg_done_reg <= (seg_rem_reg == seg_step);
      end
    end
  end

  // ---------------- command sum ----------------
  // profile moves add on top of the gear without disturbing it
  wire [31:0] profile_sum = sources.profile + seg_pos_reg;
  wire [31:0] total_next = profile_sum + sources.jog + ext_pos_reg + sources.cam;
  logic [31:0] total_reg;      // registered total command

  // total command is registered so the loop sees a clean word
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      total_reg <= 32'h0;
    end else begin
      total_reg <= total_next;
    end
  end

  // ---------------- control registers and read port ----------------
  wire [31:0] status_word = {25'h0, following, seg_done_reg, seg_branch_reg, seg_active,
                             pause_busy, lag_reg, limiting_reg};
  logic [31:0] rd_mux;

  // read selection; unmapped offsets read zero
  always_comb begin
    case (req.addr)
      gear_feed_pkg::CTRL_OFS: rd_mux = {24'h0, ctrl_reg};
      gear_feed_pkg::RATIO_OFS: rd_mux = ratio_reg;
      gear_feed_pkg::SLEW_OFS: rd_mux = slew_reg;
      gear_feed_pkg::FEED_OFS: rd_mux = {24'h0, eff_feed};
      gear_feed_pkg::FEED_DEF_OFS: rd_mux = {24'h0, feed_def_reg};
      gear_feed_pkg::DWELL_OFS: rd_mux = dwell_reg;
      gear_feed_pkg::DELAY_OFS: rd_mux = delay_reg;
      gear_feed_pkg::SEG_DIST_OFS: rd_mux = seg_rem_reg;
      gear_feed_pkg::SEG_VEL_OFS: rd_mux = seg_vel_reg;
      gear_feed_pkg::STATUS_OFS: rd_mux = status_word;
      gear_feed_pkg::EXT_POS_OFS: rd_mux = ext_pos_reg;
      gear_feed_pkg::TOTAL_OFS: rd_mux = total_reg;
      default: rd_mux = 32'h0;
    endcase
  end

  // control writes and the one-cycle read answer; ratio may change while following
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_reg <= gear_feed_pkg::CTRL_RST;
      ratio_reg <= gear_feed_pkg::RATIO_RST;
      slew_reg <= gear_feed_pkg::SLEW_RST;
      rdata_reg <= 32'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= req.wdata[gear_feed_pkg::CTRL_WIDTH-1:0];
      end
      if (wr_ratio) begin
        ratio_reg <= req.wdata;
      end
      if (wr_slew) begin
        slew_reg <= req.wdata;
      end
      rdata_reg <= req.rd ? rd_mux : 32'h0;
    end
  end

  // outputs
  assign rdata = rdata_reg;
  assign total_cmd = total_reg;
  assign external_command_component = ext_pos_reg;
  assign motion_tick = mtick_reg;
  assign one_way_limiting_flag = limiting_reg;
  assign pause_busy = (dwell_reg != 32'h0) || (delay_reg != 32'h0);

endmodule

// file: verification/electronic_gear_feedrate_asserts.sv
// port checker for the gear and feedrate block
module electronic_gear_feedrate_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire gear_feed_pkg::reg_req_t req,
  input wire logic [31:0] rdata,
  input wire logic drive_enable,
  input wire logic [31:0] external_command_component,
  input wire logic motion_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // short names for the watched values
  wire [7:0] a = req.addr;
  wire [31:0] ext = external_command_component;
  // a ratio write and its read-back three cycles on
  sequence s_ratio_wr;
    req.wr && a == gear_feed_pkg::RATIO_OFS;
  endsequence
  sequence s_ratio_rd;
    req.rd && a == gear_feed_pkg::RATIO_OFS;
  endsequence
  // writes that stop following or stop the timebase
  sequence s_follow_off;
    req.wr && a == gear_feed_pkg::CTRL_OFS && !req.wdata[0];
  endsequence
  sequence s_feed_zero;
    req.wr && a == gear_feed_pkg::FEED_OFS && req.wdata == 32'h0;
  endsequence
  property p_feed_cap;
    req.rd && a == gear_feed_pkg::FEED_OFS |=> rdata <= 32'hc8;
  endproperty
  a_feed_cap: assert property (p_feed_cap) else $error("feed above cap");
  property p_def_cap;
    req.rd && a == gear_feed_pkg::FEED_DEF_OFS |=> rdata <= 32'hc8;
  endproperty
  a_def_cap: assert property (p_def_cap) else $error("default feed above cap");
  property p_ratio_back;
    s_ratio_wr ##3 s_ratio_rd |=> rdata == $past(req.wdata, 4);
  endproperty
  a_ratio_back: assert property (p_ratio_back) else $error("ratio lost");
  // gear position moves only on its sample tick, never twice close together
  property p_ext_hold;
    $changed(ext) |=> $stable(ext) [*8];
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("gear position jitter");
  // the pin filter needs four cycles, so eight low samples are safely past it
  property p_drive_off;
    !drive_enable [*8] |=> $stable(ext);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("moves while disabled");
  property p_follow_off;
    s_follow_off |-> ##3 $stable(ext) [*8];
  endproperty
  a_follow_off: assert property (p_follow_off) else $error("moves unfollowed");
  property p_feed_stop;
    s_feed_zero |-> ##4 !motion_tick [*8];
  endproperty
  a_feed_stop: assert property (p_feed_stop) else $error("tick at zero feed");
  property p_quiet_start;
    $fell(reset) |-> !motion_tick [*8];
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("early tick");
endmodule

bind electronic_gear_feedrate electronic_gear_feedrate_asserts chk_u (.mclk(mclk),
  .reset(reset), .req(req), .rdata(rdata), .drive_enable(drive_enable),
  .external_command_component(external_command_component), .motion_tick(motion_tick));

// file: verification/master_source.sv
// behavioural master encoder or step and direction source
module master_source (
  input wire logic mclk,
  input wire logic go,
  input wire logic step_mode,
  input wire logic down,
  input wire logic [7:0] count,
  output logic enc_a,
  output logic enc_b,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GAP = 8; // longer than the pin filter, so no edge is merged
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    busy = 1'b0;
  end
  // one count every gap, one step every two gaps; lines hold their level between bursts
  always @(posedge mclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < count; i++) begin
        if (step_mode) begin
          enc_b <= down;
          enc_a <= 1'b0;
          repeat (GAP) @(posedge mclk);
          enc_a <= 1'b1;
        end else if (down == (enc_a == enc_b)) begin
          enc_a <= !enc_a;
        end else begin
          enc_b <= !enc_b;
        end
        repeat (GAP) @(posedge mclk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// file: verification/electronic_gear_feedrate_tb.sv
// self-checking bench for the gear and feedrate block
module electronic_gear_feedrate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  gear_feed_pkg::reg_req_t req = '0;
  gear_feed_pkg::cmd_sources_t sources = '0;
  logic drive_enable = 1'b0;
  logic program_running = 1'b0;
  logic go = 1'b0;
  logic step_mode = 1'b0;
  logic down = 1'b0;
  logic [7:0] count = 8'h00;
  logic [31:0] pos = 32'h0; // expected gear position
  logic [7:0] analog = 8'hff;
  logic [31:0] rdata, total_cmd, ext;
  logic enc_a, enc_b, motion_tick, flag, pause_busy, busy;
  int err_total = 0;
  int samples_checked = 0;
  // condition input stays idle: segments are not run
  electronic_gear_feedrate dut_u (.mclk(mclk), .reset(reset), .req(req), .rdata(rdata),
    .enc_a(enc_a), .enc_b(enc_b), .cond_in(1'b0), .drive_enable(drive_enable),
    .program_running(program_running), .analog_feed(analog), .sources(sources),
    .total_cmd(total_cmd), .external_command_component(ext), .motion_tick(motion_tick),
    .one_way_limiting_flag(flag), .pause_busy(pause_busy));
  master_source src_u (.mclk(mclk), .go(go), .step_mode(step_mode), .down(down),
    .count(count), .enc_a(enc_a), .enc_b(enc_b), .busy(busy));
  always #5 mclk = ~mclk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, exp, what);
  endtask
  // burst from the source, then two gear samples for the position to land
  task automatic move(input logic [7:0] n, input logic dn, input logic [31:0] exp,
      input string what);
    @(posedge mclk);
    count <= n;
    down <= dn;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i == 3000) begin
        err_total++;
        finish_test();
      end
      @(posedge mclk);
    end
    repeat (2100) @(posedge mclk);
    @(negedge mclk);
    pos = pos + exp;
    chk(ext, pos, what);
  endtask
  task automatic t_reset();
    logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h30};
    logic [31:0] val [6] = '{32'h0, 32'h1_0000, 32'h1, 32'h64, 32'h64, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd_chk(ofs[i], val[i], "reset value");
    end
    $display("test reset done");
  endtask
  task automatic t_gear();
    wr(8'h00, 32'h1);
    drive_enable <= 1'b1;
    move(8'd10, 1'b0, 32'ha, "unit ratio");
    wr(8'h04, 32'h0000_aaab);
    for (int k = 0; k < 3; k++) begin
      move(8'd1, 1'b0, {31'h0, k > 0}, "fraction carry");
    end
    wr(8'h04, 32'hffff_0000);
    move(8'd5, 1'b0, 32'hffff_fffb, "negative ratio");
    step_mode <= 1'b1;
    wr(8'h00, 32'h5);
    wr(8'h04, 32'h2_0000);
    rd_chk(8'h04, 32'h2_0000, "ratio readback");
    move(8'd4, 1'b1, 32'hffff_fff8, "step scaling");
    step_mode <= 1'b0;
    wr(8'h00, 32'h1);
    $display("test gear done");
  endtask
  task automatic t_stop();
    wr(8'h00, 32'h0);
    move(8'd6, 1'b0, 32'h0, "follow off");
    wr(8'h00, 32'h1);
    drive_enable <= 1'b0;
    move(8'd6, 1'b0, 32'h0, "drive off");
    @(posedge mclk);
    drive_enable <= 1'b1;
    $display("test stop done");
  endtask
  task automatic t_prog();
    wr(8'h10, 32'h96);
    program_running <= 1'b1;
    wr(8'h0c, 32'hff);
    rd_chk(8'h0c, 32'hc8, "feed clamp");
    @(posedge mclk);
    program_running <= 1'b0;
    rd_chk(8'h0c, 32'h96, "feed revert");
    move(8'd3, 1'b0, 32'h6, "after program");
    $display("test program done");
  endtask
  // recover type: blocked reverse counts are paid back before forward motion
  task automatic t_lim();
    wr(8'h00, 32'h41);
    move(8'd3, 1'b1, 32'h0, "reverse blocked");
    chk({31'h0, flag}, 32'h1, "limit set");
    move(8'd5, 1'b0, 32'h4, "paid back");
    chk({31'h0, flag}, 32'h0, "limit clear");
    $display("test limit done");
  endtask
  // ticks over ten base periods: a tenth of the percentage
  task automatic t_feed();
    logic [31:0] n;
    logic [31:0] pct [3] = '{32'd0, 32'd100, 32'd200};
    for (int i = 0; i < 3; i++) begin
      wr(8'h0c, pct[i]);
      repeat (1000) @(posedge mclk);
      n = 0;
      repeat (10000) begin
        @(posedge mclk);
        if (motion_tick === 1'b1) begin
          n++;
        end
      end
      chk(n, pct[i] / 10, "tick rate");
    end
    $display("test feed done");
  endtask
  // zero feed holds a dwell; a short wait lets ticks already owed drain first
  task automatic t_pause();
    wr(8'h0c, 32'h0);
    repeat (4) @(posedge mclk);
    wr(8'h14, 32'h1);
    repeat (2000) @(posedge mclk);
    rd_chk(8'h14, 32'h64, "dwell held");
    chk({31'h0, pause_busy}, 32'h1, "busy");
    wr(8'h14, 32'h0);
    @(negedge mclk);
    chk({31'h0, pause_busy}, 32'h0, "idle");
    wr(8'h00, 32'h80);
    rd_chk(8'h0c, 32'hc8, "analog feed");
    $display("test pause done");
  endtask
  task automatic t_sum();
    @(posedge mclk);
    sources <= '{profile: 32'h100, jog: 32'h20, cam: 32'h3};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk(total_cmd, 32'h123 + pos, "command sum");
    $display("test sum done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_gear();
    t_stop();
    t_prog();
    t_lim();
    t_feed();
    t_pause();
    t_sum();
    finish_test();
  end
endmodule
